// ==== core/irq_flag_logic.sv ====
/*
 * Peripheral interrupt flag logic: timer flags cleared by write-one,
 * serial receive-full flag cleared by status read then data read,
 * per-source enables, global mask in the condition code register,
 * AHB-Lite slave with sticky event status, mask and one interrupt line.
 * Assumes a single AHB-Lite master issuing single word transfers, and
 * event pins asynchronous to hclk.
 */
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
// Contract
// - Flag and enable per source; request when both
// - Flags set regardless of enable
// - Global mask bit blocks all requests; here only irq_request, bus_irq follows irq_mask alone
// - Timer flags cleared only by written ones
// - Status read then data read clears receive-full
// - Any data register read counts, including RMW
// - Request is a level until flag cleared
`timescale 1ns/10ps
`include "irq_flag_map.svh"
module irq_flag_logic
	import irq_flag_pkg::*;
#(
	parameter int TIMER_SOURCES = 8
)
(
	// Bus clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [11:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// Peripheral event pins
	input  wire logic [TIMER_SOURCES-1:0] timer_event,
	input  wire logic                     rx_event,
	// Requests to the core
	output logic                          irq_request,
	output logic                          bus_irq
);
	// Flag and enable words are sliced from one bus word
	if (TIMER_SOURCES < 1 || TIMER_SOURCES > 32)
	begin : bad_timer_sources
		$error("TIMER_SOURCES must lie in 1..32");
	end

	localparam int NP = TIMER_SOURCES + 1;

	// Synchronised event pins and edge detect
	logic [NP-1:0] ev_level;
	logic [NP-1:0] ev_prev;
	pin_sync #(.WIDTH(NP)) u_sync
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_in    ({rx_event, timer_event}),
		.level_out (ev_level)
	);
	wire [NP-1:0]            ev_rise  = ev_level & ~ev_prev;
	wire [TIMER_SOURCES-1:0] timer_set = ev_rise[TIMER_SOURCES-1:0];
	wire                     rx_set    = ev_rise[NP-1];

	// Register state
	logic [TIMER_SOURCES-1:0] timer_flag;
	logic [TIMER_SOURCES-1:0] timer_enable;
	logic                     rx_full;
	logic                     rx_enable;
	logic [7:0]               condition_code_register;
	logic [1:0]               irq_status;
	logic [1:0]               irq_mask;
	rx_clear_e                rx_state;

	// Address phase capture
	logic        dp_valid;
	logic        dp_write;
	logic [11:0] dp_addr;
	wire         ap_take  = hsel & htrans[1] & hready;
	wire         ap_read  = ap_take & ~hwrite;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	wire wr_tstat = dp_valid & dp_write & hit(dp_addr, `OFS_TIMER_STATUS);
	wire wr_ten   = dp_valid & dp_write & hit(dp_addr, `OFS_TIMER_ENABLE);
	wire wr_sen   = dp_valid & dp_write & hit(dp_addr, `OFS_SERIAL_ENABLE);
	wire wr_cond  = dp_valid & dp_write & hit(dp_addr, `OFS_CONDITION_CODE);
	wire wr_istat = dp_valid & dp_write & hit(dp_addr, `OFS_IRQ_STATUS);
	wire wr_imask = dp_valid & dp_write & hit(dp_addr, `OFS_IRQ_MASK);
	// Reads decoded in the address phase so data is ready in the data phase
	wire rd_sstat = ap_read & hit(haddr, `OFS_SERIAL_STATUS);
	// Any access to data reads it first: a write here models the RMW operand read
	wire rd_sdata = ap_take & hit(haddr, `OFS_SERIAL_DATA);

	// Set wins over a same-cycle write-one clear, so no event is lost
	function automatic word_t sticky(input word_t flags, input word_t set, input word_t clear);
		sticky = set | (flags & ~clear);
	endfunction

	// Timer flags: zeros written leave bits alone
	wire [TIMER_SOURCES-1:0] timer_clear = wr_tstat ? hwdata[TIMER_SOURCES-1:0] : '0;
	wire word_t              timer_word  = sticky(word_t'(timer_flag), word_t'(timer_set), word_t'(timer_clear));
	wire [TIMER_SOURCES-1:0] next_timer  = timer_word[TIMER_SOURCES-1:0];

	// Receive-full two-step clear; arm only on status read while set
	wire rx_clear   = (rx_state == RX_ARMED) & rd_sdata & rx_full;
	wire next_rx    = rx_set | (rx_full & ~rx_clear);
	rx_clear_e next_rx_state;
	always_comb
	begin
		next_rx_state = rx_state;
		case (rx_state)
			RX_IDLE:
				if (rd_sstat && rx_full)
					next_rx_state = RX_ARMED;
			RX_ARMED:
				if (rd_sdata || !rx_full)
					next_rx_state = RX_IDLE;
			default:
				next_rx_state = RX_IDLE;
		endcase
	end

	// Request: flag and enable per source, gated by global mask, held as a level
	wire any_req  = |(timer_flag & timer_enable) | (rx_full & rx_enable);
	wire next_req = any_req & ~condition_code_register[`BIT_GLOBAL_MASK];
	wire req_rise = next_req & ~irq_request;

	// Bus-side event status: request rising, receive overrun
	wire [1:0] ev_new;
	assign ev_new[`BIT_EV_IRQ_RISE]   = req_rise;
	assign ev_new[`BIT_EV_RX_OVERRUN] = rx_set & rx_full;
	wire [1:0] istat_clear = wr_istat ? hwdata[1:0] : 2'h0;
	wire word_t istat_word = sticky(word_t'(irq_status), word_t'(ev_new), word_t'(istat_clear));
	wire [1:0] next_istat  = istat_word[1:0];

	// Read mux, selected in the address phase
	word_t rd_word;
	always_comb
	begin
		rd_word = `RST_ZERO;
		if (hit(haddr, `OFS_TIMER_STATUS))
			rd_word[TIMER_SOURCES-1:0] = timer_flag;
		else if (hit(haddr, `OFS_TIMER_ENABLE))
			rd_word[TIMER_SOURCES-1:0] = timer_enable;
		else if (hit(haddr, `OFS_SERIAL_STATUS))
			rd_word[`BIT_RX_FULL] = rx_full;
		else if (hit(haddr, `OFS_SERIAL_ENABLE))
			rd_word[0] = rx_enable;
		else if (hit(haddr, `OFS_CONDITION_CODE))
			rd_word[7:0] = condition_code_register;
		else if (hit(haddr, `OFS_IRQ_STATUS))
			rd_word[1:0] = irq_status;
		else if (hit(haddr, `OFS_IRQ_MASK))
			rd_word[1:0] = irq_mask;
		else if (hit(haddr, `OFS_REQ_VIEW))
			rd_word[0] = any_req;
	end

	// Register writes land at the end of the data phase
	wire [TIMER_SOURCES-1:0] next_timer_enable = wr_ten ? hwdata[TIMER_SOURCES-1:0] : timer_enable;
	wire                     next_rx_enable    = wr_sen ? hwdata[0] : rx_enable;
	wire [7:0]               next_condition    = wr_cond ? hwdata[7:0] : condition_code_register;
	wire [1:0]               next_irq_mask     = wr_imask ? hwdata[1:0] : irq_mask;
	wire                     next_bus_irq      = |(next_istat & irq_mask);
	word_t                   next_hrdata;
	assign next_hrdata = ap_read ? rd_word : `RST_ZERO;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dp_valid <= 1'b0;
		else
			dp_valid <= ap_take;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dp_write <= 1'b0;
		else
			dp_write <= hwrite;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dp_addr <= 12'h000;
		else
			dp_addr <= haddr;
	end

	// Zero outside read data phases, so stale words never linger on the bus
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= `RST_ZERO;
		else
			hrdata <= next_hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ev_prev <= '0;
		else
			ev_prev <= ev_level;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_flag <= '0;
		else
			timer_flag <= next_timer;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_enable <= '0;
		else
			timer_enable <= next_timer_enable;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_full <= 1'b0;
		else
			rx_full <= next_rx;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_enable <= 1'b0;
		else
			rx_enable <= next_rx_enable;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_state <= RX_IDLE;
		else
			rx_state <= next_rx_state;
	end

	// Comes out of reset masked, so nothing reaches the core before software is ready
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			condition_code_register <= `RST_CONDITION_CODE;
		else
			condition_code_register <= next_condition;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_status <= 2'h0;
		else
			irq_status <= next_istat;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_mask <= 2'h0;
		else
			irq_mask <= next_irq_mask;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_request <= 1'b0;
		else
			irq_request <= next_req;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bus_irq <= 1'b0;
		else
			bus_irq <= next_bus_irq;
	end

	// No wait states, no error response; still flops so every output is registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule

// ==== core/irq_flag_map.svh ====
/*
 * Register offsets, field positions, reset values for the peripheral
 * interrupt flag block. Assumes inclusion by bare name from core/.
 */
`ifndef IRQ_FLAG_MAP_SVH
`define IRQ_FLAG_MAP_SVH

`define OFS_TIMER_STATUS   12'h000
`define OFS_TIMER_ENABLE   12'h004
`define OFS_SERIAL_STATUS  12'h008
`define OFS_SERIAL_DATA    12'h00C
`define OFS_SERIAL_ENABLE  12'h010
`define OFS_CONDITION_CODE 12'h014
`define OFS_IRQ_STATUS     12'h018
`define OFS_IRQ_MASK       12'h01C
`define OFS_REQ_VIEW       12'h020

`define BIT_RX_FULL        0
`define BIT_GLOBAL_MASK    4
`define BIT_EV_IRQ_RISE    0
`define BIT_EV_RX_OVERRUN  1

`define RST_CONDITION_CODE 8'h10
`define RST_ZERO           32'h0000_0000

`endif

// ==== core/irq_flag_pkg.sv ====
/*
 * Types shared by the peripheral interrupt flag block.
 * Assumes the map header is compiled alongside.
 */
package irq_flag_pkg;
	typedef enum logic [1:0]
	{
		RX_IDLE,
		RX_ARMED
	} rx_clear_e;
	typedef logic [31:0] word_t;
endpackage

// ==== core/pin_sync.sv ====
/*
 * Three-stage synchroniser for a bus of event pins.
 * Assumes pins are asynchronous to hclk; output changes when stages two and three agree.
 */
`timescale 1ns/10ps
module pin_sync
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Pins in, filtered level out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	if (WIDTH < 1)
	begin : bad_width
		$error("WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level_out);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage1    <= '0;
			stage2    <= '0;
			stage3    <= '0;
			level_out <= '0;
		end
		else
		begin
			stage1    <= pin_in;
			stage2    <= stage1;
			stage3    <= stage2;
			level_out <= next_level;
		end
	end
endmodule

// ==== testbench/cpu_model.sv ====
/* Processor core model issuing single AHB-Lite word transfers.
   Assumes hready is the slave's hreadyout; used after reset release. */
`timescale 1ns/10ps
module cpu_model
(
	// Clock and ready
	input wire logic		hclk,
	input wire logic		hready,
	// Master outputs
	output logic			hsel,
	output logic [11:0]	haddr,
	output logic [1:0]	htrans,
	output logic			hwrite,
	output logic [2:0]	hsize,
	output logic [31:0]	hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (!hready);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hready);
		// Released data never repeats the last word
		hwdata <= ~d;
	endtask
endmodule

// ==== testbench/irq_flag_logic_props.sv ====
/* Assertions on the flag block's bus and request pins.
   Bound into irq_flag_logic; sees its ports only. */
`timescale 1ns/10ps
`include "irq_flag_map.svh"
module irq_flag_logic_props
#(
	parameter int TIMER_SOURCES = 8
)
(
	// Clock, reset and bus
	input wire logic			hclk,
	input wire logic			hresetn,
	input wire logic			hsel,
	input wire logic [11:0]		haddr,
	input wire logic [1:0]		htrans,
	input wire logic			hwrite,
	input wire logic [2:0]		hsize,
	input wire logic [31:0]		hwdata,
	input wire logic			hready,
	input wire logic [31:0]		hrdata,
	input wire logic			hreadyout,
	input wire logic			hresp,
	// Events and requests
	input wire logic [TIMER_SOURCES-1:0]	timer_event,
	input wire logic			rx_event,
	input wire logic			irq_request,
	input wire logic			bus_irq
);
	logic				dv;
	logic				dw;
	logic [11:0]			da;
	logic				i_set;
	logic [3:0]			acc_age;
	logic [3:0]			ev_age;
	logic [TIMER_SOURCES:0]	pins_q;
	wire logic			cond_wr = dv && dw && da == `OFS_CONDITION_CODE;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Ages saturate so an old cause never looks recent
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dv <= 1'b0;
			dw <= 1'b0;
			da <= 12'h000;
			i_set <= 1'b1;
			acc_age <= 4'hF;
			ev_age <= 4'hF;
			pins_q <= '0;
		end
		else
		begin
			if (hready)
			begin
				dv <= hsel && htrans[1];
				dw <= hwrite;
				da <= haddr;
			end
			if (cond_wr)
				i_set <= hwdata[`BIT_GLOBAL_MASK];
			acc_age <= (hsel && htrans[1]) ? 4'h0 : acc_age + {3'h0, acc_age != 4'hF};
			ev_age <= (pins_q != {rx_event, timer_event}) ? 4'h0 : ev_age + {3'h0, ev_age != 4'hF};
			pins_q <= {rx_event, timer_event};
		end
	end
	property p_mask_blocks; cond_wr && hwdata[`BIT_GLOBAL_MASK] |-> ##2 !irq_request; endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("mask ignored");
	property p_masked_quiet; i_set [*4] |-> !irq_request; endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("request while masked");
	property p_rise_cause; $rose(irq_request) |-> acc_age < 4'h6 || ev_age < 4'hC; endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("request without cause");
	property p_level_hold; $fell(irq_request) |-> acc_age < 4'h6; endproperty
	a_level_hold: assert property (p_level_hold) else $error("request dropped alone");
	property p_bus_irq_hold; $fell(bus_irq) |-> acc_age < 4'h6; endproperty
	a_bus_irq_hold: assert property (p_bus_irq_hold) else $error("bus_irq dropped alone");
	property p_unmapped; dv && !dw && da > `OFS_REQ_VIEW |-> hrdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	c_rise: cover property ($rose(irq_request));
	c_fall: cover property ($fell(irq_request));
	c_bus_irq: cover property ($rose(bus_irq));
endmodule
bind irq_flag_logic irq_flag_logic_props #(.TIMER_SOURCES(TIMER_SOURCES)) props (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_event, .rx_event,
	.irq_request, .bus_irq);

// ==== testbench/test_irq_flag_logic.sv ====
/* Self-checking bench: core model on the bus, event pins from here.
   Assumes the map header and package are compiled first. */
`timescale 1ns/10ps
`include "irq_flag_map.svh"
module test_irq_flag_logic
	import irq_flag_pkg::*;
;
	logic			hclk, hresetn, rx_event;
	logic			rd_ph = 1'b0;
	logic [31:0]		seed;
	logic [7:0]		timer_event, r;
	wire logic		hsel, hwrite, hrdy, hresp, irq_request, bus_irq;
	wire logic [11:0]	haddr;
	wire logic [1:0]	htrans;
	wire logic [2:0]	hsize;
	wire logic [31:0]	hwdata;
	wire word_t		hrdata;
	word_t			q[$], e;
	int			n_mismatch, checked;
	cpu_model cpu (.hclk, .hready(hrdy), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	irq_flag_logic uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy),
		.hrdata, .hreadyout(hrdy), .hresp, .timer_event, .rx_event, .irq_request, .bus_irq);
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task summarize;
		$display("counts: %0d checked, %0d mismatched", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic g, input logic x);
		checked++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("mismatch %s exp %b got %b", n, x, g);
		end
	endtask
	task rd(input logic [11:0] a, input word_t x);
		q.push_back(x);
		cpu.xfer(1'b0, a, 32'h0);
	endtask
	task w4;
		repeat (4) @(posedge hclk);
	endtask
	task pulse(input logic [7:0] t, input logic x);
		timer_event <= t;
		rx_event <= x;
		repeat (8) @(posedge hclk);
		timer_event <= 8'h00;
		rx_event <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask
	// Read data is judged at the edge that ends its data phase
	always @(posedge hclk)
	begin
		if (rd_ph && hrdy)
		begin
			e = q.pop_front();
			checked++;
			if (hrdata !== e)
			begin
				n_mismatch++;
				$display("mismatch hrdata exp %h got %h", e, hrdata);
			end
		end
		if (hrdy)
			rd_ph <= hsel && htrans[1] && !hwrite;
	end
	initial
	begin
		repeat (3000) @(posedge hclk);
		n_mismatch++;
		$display("watchdog expired");
		summarize();
	end
	initial
	begin
		{hresetn, rx_event, n_mismatch, checked} = '0;
		timer_event = 8'h00;
		seed = xs(32'hD51076D3);
		r = seed[7:0] | 8'h01;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`OFS_CONDITION_CODE, 32'h10);
		pulse(r, 1'b0);
		rd(`OFS_TIMER_STATUS, {24'h0, r});
		cpu.xfer(1'b1, `OFS_TIMER_ENABLE, 32'hFF);
		w4();
		chk("irq_request", irq_request, 1'b0);
		cpu.xfer(1'b1, `OFS_CONDITION_CODE, 32'h0);
		w4();
		chk("irq_request", irq_request, 1'b1);
		cpu.xfer(1'b1, `OFS_TIMER_STATUS, 32'h0);
		w4();
		chk("irq_request", irq_request, 1'b1);
		rd(`OFS_TIMER_STATUS, {24'h0, r});
		cpu.xfer(1'b1, `OFS_CONDITION_CODE, 32'h10);
		w4();
		chk("irq_request", irq_request, 1'b0);
		rd(`OFS_REQ_VIEW, 32'h1);
		cpu.xfer(1'b1, `OFS_CONDITION_CODE, 32'h0);
		w4();
		chk("irq_request", irq_request, 1'b1);
		cpu.xfer(1'b1, `OFS_TIMER_STATUS, 32'h1);
		rd(`OFS_TIMER_STATUS, {24'h0, r & 8'hFE});
		cpu.xfer(1'b1, `OFS_TIMER_STATUS, {24'h0, r});
		w4();
		chk("irq_request", irq_request, 1'b0);
		rd(`OFS_TIMER_STATUS, 32'h0);
		$display("timer test done");
		pulse(8'h00, 1'b1);
		cpu.xfer(1'b1, `OFS_SERIAL_ENABLE, 32'h1);
		rd(`OFS_SERIAL_DATA, 32'h0);
		w4();
		chk("irq_request", irq_request, 1'b1);
		pulse(8'h00, 1'b1);
		rd(`OFS_SERIAL_STATUS, 32'h1);
		cpu.xfer(1'b1, `OFS_SERIAL_DATA, 32'h0);
		w4();
		chk("irq_request", irq_request, 1'b0);
		rd(`OFS_SERIAL_STATUS, 32'h0);
		$display("serial test done");
		rd(`OFS_IRQ_STATUS, 32'h3);
		cpu.xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
		w4();
		chk("bus_irq", bus_irq, 1'b1);
		cpu.xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
		w4();
		chk("bus_irq", bus_irq, 1'b0);
		cpu.xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
		cpu.xfer(1'b1, `OFS_IRQ_STATUS, 32'h3);
		w4();
		chk("bus_irq", bus_irq, 1'b0);
		rd(`OFS_IRQ_STATUS, 32'h0);
		rd(12'h040, 32'h0);
		w4();
		$display("status test done");
		summarize();
	end
endmodule
